// [src/step_atten_control_port.sv]
// step attenuator control port: pin sync, serial shifter, code latch, axi4-lite
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
module step_atten_control_port
  import atten_pkg::*;
#(
  parameter int PWR_CYC = PWR_CYC_DEF
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [REG_AW-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [REG_AW-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  input  wire logic              shift_clk,
  input  wire logic              serial_in,
  input  wire logic              interface_select,
  input  wire logic              word_strobe,
  input  wire logic [CODE_W-1:0] parallel_code,
  output logic [CODE_W-1:0]      atten_code
);

  localparam int CNT_W = $clog2(PWR_CYC + 1);

  pin_in_s           pin_raw;
  pin_in_s           pin_f;
  logic [PIN_W-1:0]  filt_v;
  logic              strobe_d_reg;
  logic              strobe_rise;
  logic [WORD_W-1:0] link_word_reg;
  logic [WORD_W-1:0] shift_cap_reg;
  logic [CODE_W-1:0] code_reg;
  logic [CODE_W-1:0] src;
  pwr_state_e        pwr_state_reg;
  logic [CNT_W-1:0]  pwr_cnt_reg;
  logic              pwr_run;
  logic              force_max_reg;
  logic [COUNT_W-1:0] latch_cnt_reg;
  logic              lrst_s1_reg;
  logic              lrst_s2_reg;
  logic              lrst_n_reg;
  logic              awready_reg;
  logic              wready_reg;
  logic              aw_have_reg;
  logic              w_have_reg;
  logic [REG_AW-1:0] waddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic              do_write;
  logic [31:0]       rd_mux;
  status_s           status;

  // word-aligned register hit
  function automatic logic reg_hit(input logic [REG_AW-1:0] a);
    logic [REG_AW-1:0] w;
    w = {a[REG_AW-1:2], 2'b00};
    return (w == STATUS_OFF) || (w == WORD_OFF) || (w == CTRL_OFF) || (w == COUNT_OFF);
  endfunction : reg_hit

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  assign pin_raw = {interface_select, word_strobe, parallel_code};
  assign pin_f   = filt_v;

  // three stages; a change only counts once stages two and three agree
  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic f_reg;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
        f_reg  <= 1'b0;
      end else begin
        s1_reg <= pin_raw[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) begin
          f_reg <= s3_reg;
        end
      end
    end
    assign filt_v[i] = f_reg;
  end

  // ---------------------------------------------------------------
  // link domain: serial shifter on the shift clock
  // ---------------------------------------------------------------
  // reset carried over into the link domain; only valid while the clock runs
  always_ff @(posedge shift_clk) begin
    lrst_s1_reg <= aresetn;
    lrst_s2_reg <= lrst_s1_reg;
    lrst_n_reg  <= lrst_s2_reg;
  end

  // serial_in shifts on the link clock itself
  // lsb first: new bit enters at the top and walks down to bit 0
  // strobe high freezes the shifter; parallel select too
  always_ff @(posedge shift_clk) begin
    if (!lrst_n_reg) begin
      link_word_reg <= WORD_RST;
    end else if (interface_select && !word_strobe) begin
      link_word_reg <= {serial_in, link_word_reg[WORD_W-1:1]};
    end
  end

  // ---------------------------------------------------------------
  // word capture across the domains
  // ---------------------------------------------------------------
  // shifter is frozen while strobe is high, so a single capture on the
  // filtered rising edge is safe; capturing later risks a restarted shift
  assign strobe_rise = pin_f.strobe && !strobe_d_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_d_reg <= 1'b0;
    end else begin
      strobe_d_reg <= pin_f.strobe;
    end
  end

  // strobe pulse moves the shifter word into the holding latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_cap_reg <= WORD_RST;
    end else if (strobe_rise && pin_f.select) begin
      shift_cap_reg <= link_word_reg;
    end
  end

  // ---------------------------------------------------------------
  // power-up sequencing
  // ---------------------------------------------------------------
  // count out the power-up delay before any code is accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_state_reg <= PWR_WAIT;
      pwr_cnt_reg   <= '0;
    end else begin
      case (pwr_state_reg)
        PWR_WAIT: begin
          pwr_cnt_reg <= pwr_cnt_reg + CNT_W'(1);
          if (pwr_cnt_reg == CNT_W'(PWR_CYC - 1)) begin
            pwr_state_reg <= PWR_RUN;
          end
        end
        PWR_RUN: begin
          pwr_cnt_reg <= pwr_cnt_reg;
        end
        default: begin
          pwr_state_reg <= PWR_WAIT;
          pwr_cnt_reg   <= '0;
        end
      endcase
    end
  end

  assign pwr_run = (pwr_state_reg == PWR_RUN);

  // ---------------------------------------------------------------
  // attenuation latch
  // ---------------------------------------------------------------
  // select picks the source; other interface is never looked at
  // serial bit 7 dropped; parallel lines form the code
  assign src = pin_f.select ? shift_cap_reg[CODE_W-1:0] : pin_f.code;

  // reset and power-up wait both hold maximum attenuation
  // transparent while strobe high, holds on its fall
  // strobe tied high makes it follow the lines; low lines give min
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_reg <= CODE_MAX;
    end else if (force_max_reg || !pwr_run) begin
      code_reg <= CODE_MAX;
    end else if (pin_f.strobe) begin
      code_reg <= src;
    end
  end

  assign atten_code = code_reg;

  // words latched since reset, wraps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_cnt_reg <= '0;
    end else if (strobe_rise && pwr_run) begin
      latch_cnt_reg <= latch_cnt_reg + COUNT_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write side
  // ---------------------------------------------------------------
  assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;

  // write address: one outstanding, reopened after the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      aw_have_reg <= 1'b0;
      waddr_reg   <= '0;
    end else if (awvalid && awready_reg) begin
      awready_reg <= 1'b0;
      aw_have_reg <= 1'b1;
      waddr_reg   <= awaddr;
    end else begin
      if (bvalid_reg && bready) begin
        aw_have_reg <= 1'b0;
      end
      awready_reg <= !aw_have_reg && !bvalid_reg;
    end
  end

  // write data, taken independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b0;
      w_have_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else if (wvalid && wready_reg) begin
      wready_reg <= 1'b0;
      w_have_reg <= 1'b1;
      wdata_reg  <= wdata;
      wstrb_reg  <= wstrb;
    end else begin
      if (bvalid_reg && bready) begin
        w_have_reg <= 1'b0;
      end
      wready_reg <= !w_have_reg && !bvalid_reg;
    end
  end

  // response once both halves are in; unmapped gets slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= reg_hit(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // control register: force maximum attenuation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      force_max_reg <= CTRL_FORCE_RST;
    end else if (do_write && waddr_reg[REG_AW-1:2] == CTRL_OFF[REG_AW-1:2] && wstrb_reg[0]) begin
      force_max_reg <= wdata_reg[CTRL_FORCE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read side
  // ---------------------------------------------------------------
  assign status = '{strobe: pin_f.strobe, select: pin_f.select,
                    pwr_done: pwr_run, code: code_reg};

  // read mux, zero above the field widths
  always_comb begin
    rd_mux = '0;
    case ({araddr[REG_AW-1:2], 2'b00})
      STATUS_OFF: rd_mux = 32'(status);
      WORD_OFF:   rd_mux = 32'(shift_cap_reg);
      CTRL_OFF:   rd_mux = 32'(force_max_reg);
      COUNT_OFF:  rd_mux = 32'(latch_cnt_reg);
      default:    rd_mux = '0;
    endcase
  end

  // data returned at the same edge that takes the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_mux;
      rresp_reg   <= reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (rvalid_reg && rready) begin
        rvalid_reg <= 1'b0;
      end
      arready_reg <= !rvalid_reg;
    end
  end

  assign awready = awready_reg;
  assign wready  = wready_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = arready_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  chk_pwr_max: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !pwr_run |=> code_reg == CODE_MAX)
    else $error("code left maximum during power-up wait");

  chk_pwr_len: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(pwr_run) |-> $past(pwr_cnt_reg) == CNT_W'(PWR_CYC - 1))
    else $error("power-up wait has wrong length");

  chk_hold_low: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (pwr_run && !pin_f.strobe && !force_max_reg) |=> $stable(code_reg))
    else $error("code moved while strobe low");

  chk_serial_path: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (pwr_run && pin_f.select && pin_f.strobe && !force_max_reg) [*2]
    |=> code_reg == shift_cap_reg[CODE_W-1:0])
    else $error("serial word not passed to code");

  chk_direct_path: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (pwr_run && !pin_f.select && pin_f.strobe && !force_max_reg)
    |=> code_reg == $past(pin_f.code))
    else $error("parallel lines not followed");

  chk_force_max: assert property (
    @(posedge aclk) disable iff (!aresetn)
    force_max_reg |=> code_reg == CODE_MAX)
    else $error("force max not honoured");

  chk_cap_rise: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (strobe_rise && pin_f.select) |=> shift_cap_reg == $past(link_word_reg))
    else $error("shifter word not captured");

  chk_shift_lsb: assert property (
    @(posedge shift_clk) disable iff (!lrst_n_reg)
    (interface_select && !word_strobe) [*8]
    |=> link_word_reg[0] == $past(serial_in, 8))
    else $error("first bit not in lsb");

  chk_shift_frozen: assert property (
    @(posedge shift_clk) disable iff (!lrst_n_reg)
    (word_strobe || !interface_select) |=> $stable(link_word_reg))
    else $error("shifter moved while frozen");

  chk_bvalid_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (bvalid_reg && !bready) |=> bvalid_reg && $stable(bresp_reg))
    else $error("write response dropped early");

  chk_rvalid_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rvalid_reg && !rready) |=> rvalid_reg && $stable(rdata_reg))
    else $error("read data dropped early");

  cov_serial_latch: cover property (
    @(posedge aclk) disable iff (!aresetn) strobe_rise && pin_f.select && pwr_run);

  cov_direct_change: cover property (
    @(posedge aclk) disable iff (!aresetn)
    pwr_run && !pin_f.select && pin_f.strobe && $changed(pin_f.code));

  cov_force_write: cover property (
    @(posedge aclk) disable iff (!aresetn) $rose(force_max_reg));

endmodule : step_atten_control_port

// [src/atten_pkg.sv]
// step attenuator control port: constants, types and register map
package atten_pkg;

  // ---------------------------------------------------------------
  // attenuation code
  // ---------------------------------------------------------------
  localparam int CODE_W = 7;
  localparam int WORD_W = 8;
  localparam logic [CODE_W-1:0] CODE_MAX = 7'h7f;
  localparam logic [CODE_W-1:0] CODE_MIN = 7'h00;
  localparam logic [WORD_W-1:0] WORD_RST = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ      = 100;
  localparam int PWR_DELAY_US = 400;
  localparam int PWR_CYC_DEF  = PWR_DELAY_US * CLK_MHZ;
  localparam int SCLK_MAX_MHZ = 10;
  localparam int SYNC_STAGES  = 3;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int REG_AW = 4;
  localparam logic [REG_AW-1:0] STATUS_OFF = 4'h0;
  localparam logic [REG_AW-1:0] WORD_OFF   = 4'h4;
  localparam logic [REG_AW-1:0] CTRL_OFF   = 4'h8;
  localparam logic [REG_AW-1:0] COUNT_OFF  = 4'hc;
  localparam int CTRL_FORCE_BIT = 0;
  localparam logic CTRL_FORCE_RST = 1'b0;
  localparam int COUNT_W = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    PWR_WAIT = 1'b0,
    PWR_RUN  = 1'b1
  } pwr_state_e;

  typedef struct packed {
    logic              select;
    logic              strobe;
    logic [CODE_W-1:0] code;
  } pin_in_s;

  localparam int PIN_W = $bits(pin_in_s);

  typedef struct packed {
    logic              strobe;
    logic              select;
    logic              pwr_done;
    logic [CODE_W-1:0] code;
  } status_s;

endpackage : atten_pkg

// [tb/atten_ctrl_model.sv]
// controller model: mode pins, parallel lines and serial frames
module atten_ctrl_model
  import atten_pkg::*;
(
  input  wire logic         aclk,
  output logic              shift_clk = 1'b0,
  output logic              serial_in = 1'b0,
  output logic              interface_select = 1'b0,
  output logic              word_strobe = 1'b0,
  output logic [CODE_W-1:0] parallel_code = '0
);
  timeunit 1ns;
  timeprecision 100ps;

  // pins change together just after an aclk edge
  task automatic set_pins(input logic sel, input logic stb, input logic [CODE_W-1:0] code);
    @(posedge aclk);
    interface_select <= sel;
    word_strobe      <= stb;
    parallel_code    <= code;
  endtask : set_pins

  // pulse held well past the pin filter, then settle time
  task automatic pulse_strobe();
    @(posedge aclk);
    word_strobe <= 1'b1;
    repeat (8) @(posedge aclk);
    word_strobe <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : pulse_strobe

  // one frame, bit 0 first; clock stands still outside frames
  task automatic send_bits(input logic [WORD_W-1:0] w);
    for (int i = 0; i < WORD_W; i++) begin
      serial_in = w[i];
      #7.5 shift_clk = 1'b1;
      #7.5 shift_clk = 1'b0;
    end
    // released line shows the inverse so a stale bit cannot pass
    serial_in = ~w[WORD_W-1];
    #20;
  endtask : send_bits
endmodule : atten_ctrl_model

// [tb/test_step_atten_control_port.sv]
// self-checking bench for the step attenuator control port
module test_step_atten_control_port
  import atten_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // short power-up wait keeps the run brief
  localparam int PWR_T = 20;

  logic                aclk    = 1'b0;
  logic                aresetn = 1'b0;
  logic                awvalid = 1'b0;
  logic                wvalid  = 1'b0;
  logic                bready  = 1'b0;
  logic                arvalid = 1'b0;
  logic                rready  = 1'b0;
  logic [REG_AW-1:0]   awaddr  = '0;
  logic [REG_AW-1:0]   araddr  = '0;
  logic [31:0]         wdata   = '0;
  logic [3:0]          wstrb   = 4'hf;
  wire logic           awready;
  wire logic           wready;
  wire logic           bvalid;
  wire logic           arready;
  wire logic           rvalid;
  wire logic [1:0]     bresp;
  wire logic [1:0]     rresp;
  wire logic [31:0]    rdata;
  wire logic           shift_clk;
  wire logic           serial_in;
  wire logic           interface_select;
  wire logic           word_strobe;
  wire logic [CODE_W-1:0] parallel_code;
  wire logic [CODE_W-1:0] atten_code;
  int                  n_mismatch = 0;
  int                  checked    = 0;
  int                  seed       = 31;
  logic [CODE_W-1:0]   r;
  logic [CODE_W-1:0]   prev;
  logic [WORD_W-1:0]   w;
  logic [31:0]         d;
  logic [31:0]         c0;

  initial begin
    forever #5 aclk = ~aclk;
  end

  step_atten_control_port #(.PWR_CYC(PWR_T)) i_step_atten_control_port (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .shift_clk, .serial_in, .interface_select,
    .word_strobe, .parallel_code, .atten_code
  );

  atten_ctrl_model i_atten_ctrl_model (
    .aclk, .shift_clk, .serial_in, .interface_select, .word_strobe, .parallel_code
  );

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // address and data offered together, each released when taken
  task automatic axi_write(input logic [REG_AW-1:0] a, input logic [31:0] v);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    bready  <= 1'b1;
    for (int t = 0; t < 100 && !got; t++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        bready <= 1'b0;
        check(32'(bresp), 32'(RESP_OKAY));
      end
    end
    if (!got) begin
      n_mismatch++;
      results();
    end
  endtask : axi_write

  task automatic axi_read(input logic [REG_AW-1:0] a, output logic [31:0] v);
    logic got;
    got = 1'b0;
    v = '0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (int t = 0; t < 100 && !got; t++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        v = rdata;
        rready <= 1'b0;
        check(32'(rresp), 32'(RESP_OKAY));
      end
    end
    if (!got) begin
      n_mismatch++;
      results();
    end
  endtask : axi_read

  // pins preset during reset, then max during the wait, then exp
  task automatic power_up(input logic sel, input logic stb, input logic [CODE_W-1:0] code,
                          input logic [CODE_W-1:0] exp);
    @(posedge aclk);
    aresetn <= 1'b0;
    i_atten_ctrl_model.set_pins(sel, stb, code);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check(32'(atten_code), 32'(CODE_MAX));
    repeat (PWR_T + 20) @(posedge aclk);
    check(32'(atten_code), 32'(exp));
    $display("power-up case done");
  endtask : power_up

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    r = 7'($random(seed));
    power_up(1'b0, 1'b1, r, r);
    power_up(1'b0, 1'b1, CODE_MIN, CODE_MIN);
    power_up(1'b1, 1'b0, CODE_MIN, CODE_MAX);
    power_up(1'b0, 1'b0, r, CODE_MAX);
    prev = CODE_MAX;
    // latched parallel: lines move freely until the pulse
    for (int k = 0; k < 4; k++) begin
      r = 7'($random(seed));
      i_atten_ctrl_model.set_pins(1'b0, 1'b0, r);
      repeat (10) @(posedge aclk);
      check(32'(atten_code), 32'(prev));
      i_atten_ctrl_model.pulse_strobe();
      check(32'(atten_code), 32'(r));
      prev = r;
    end
    // direct parallel: strobe held high, code follows the lines
    for (int k = 0; k < 4; k++) begin
      r = (k == 0) ? CODE_MAX : 7'($random(seed));
      i_atten_ctrl_model.set_pins(1'b0, 1'b1, r);
      repeat (10) @(posedge aclk);
      check(32'(atten_code), 32'(r));
      prev = r;
    end
    $display("parallel tests done");
    // serial: a junk frame first, pushed out by the real one
    for (int k = 0; k < 6; k++) begin
      w = (k == 0) ? 8'h80 : 8'($random(seed));
      i_atten_ctrl_model.set_pins(1'b1, 1'b0, CODE_MIN);
      i_atten_ctrl_model.send_bits(~w);
      i_atten_ctrl_model.send_bits(w);
      check(32'(atten_code), 32'(prev));
      i_atten_ctrl_model.pulse_strobe();
      check(32'(atten_code), {25'h0, w[6:0]});
      axi_read(WORD_OFF, d);
      check(d, {24'h0, w});
      prev = w[6:0];
    end
    // frames sent while strobe high or while parallel is selected are dropped
    i_atten_ctrl_model.set_pins(1'b1, 1'b1, CODE_MIN);
    i_atten_ctrl_model.send_bits(~w);
    i_atten_ctrl_model.set_pins(1'b0, 1'b0, CODE_MIN);
    i_atten_ctrl_model.send_bits(8'h55 ^ w);
    i_atten_ctrl_model.set_pins(1'b1, 1'b0, 7'h2a ^ prev);
    axi_read(COUNT_OFF, c0);
    i_atten_ctrl_model.pulse_strobe();
    check(32'(atten_code), 32'(prev));
    axi_read(COUNT_OFF, d);
    check(d, (c0 + 32'h1) & 32'h0000_ffff);
    i_atten_ctrl_model.set_pins(1'b1, 1'b0, CODE_MIN);
    $display("serial tests done");
    // registers: read-only write ignored, force override, low address bits
    axi_write(STATUS_OFF, 32'hffff_ffff);
    axi_read(STATUS_OFF, d);
    check(d, 32'h0000_0180 | 32'(prev));
    axi_write(CTRL_OFF, 32'h1);
    repeat (4) @(posedge aclk);
    check(32'(atten_code), 32'(CODE_MAX));
    axi_read(CTRL_OFF, d);
    check(d, 32'h1);
    axi_write(CTRL_OFF, 32'h0);
    repeat (4) @(posedge aclk);
    // force overwrote the latch, so max stays until the next strobe pulse
    check(32'(atten_code), 32'(CODE_MAX));
    // byte lane 0 masked: the force bit must not move
    wstrb <= 4'he;
    axi_write(CTRL_OFF, 32'h1);
    wstrb <= 4'hf;
    axi_read(CTRL_OFF, d);
    check(d, 32'h0);
    i_atten_ctrl_model.pulse_strobe();
    check(32'(atten_code), 32'(prev));
    axi_read(4'h5, d);
    check(d, {24'h0, w});
    $display("register tests done");
    results();
  end
endmodule : test_step_atten_control_port
